// >>> rtl/ecp_fifo.sv
// Common 16-entry byte FIFO shared by all access ports
`timescale 1ns/1ns
module ecp_fifo
  import ecp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic flush,
  input wire logic push,
  input wire fifo_word_t push_data,
  input wire logic pop,
  output fifo_word_t pop_data,
  output logic [4:0] level
);
  // Storage and pointers
  typedef struct packed {
    logic [FIFO_AW-1:0] wp;
    logic [FIFO_AW-1:0] rp;
    logic [4:0] cnt;
  } fstate_t;

  fstate_t s_q; // Registered pointers
  fstate_t s_d; // Next pointers
  fifo_word_t mem [FIFO_DEPTH]; // Shared byte store
  logic do_push; // Accepted write
  logic do_pop; // Accepted read

  assign do_push = push && (s_q.cnt != FIFO_FULL_LEVEL);
  assign do_pop = pop && (s_q.cnt != 5'h00);
  assign pop_data = mem[s_q.rp];
  assign level = s_q.cnt;

  // Pointer update
  always_comb
  begin
    s_d = s_q;
    if (flush)
    begin
      s_d = '0;
    end
    else
    begin
      if (do_push)
      begin
        s_d.wp = s_q.wp + 4'h1;
      end
      if (do_pop)
      begin
        s_d.rp = s_q.rp + 4'h1;
      end
      s_d.cnt = s_q.cnt + {4'h0, do_push} - {4'h0, do_pop};
    end
  end

  // Register pointers and write store
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
    if (do_push && !flush)
    begin
      mem[s_q.wp] <= push_data;
    end
  end
endmodule

// >>> rtl/ecp_parallel_port_engine.sv
// ECP parallel port engine: mode control, FIFO handshake, DMA and service flags
`timescale 1ns/1ns
module ecp_parallel_port_engine
  import ecp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire host_req_t HOST_REQ,
  input wire ctrl_t CTRL,
  input wire logic DMA_ACK,
  input wire logic DMA_TC,
  input wire logic EXTERNAL_FLOOPY_UNUSED_N,
  input wire logic EXTERNAL_FLOPPY_MODE,
  input wire logic MOTOR_B_IN,
  input wire logic DRIVE_SELECT_B_IN,
  input wire logic [4:0] FDD_STATUS_IN,
  input wire logic [7:0] PD_IN,
  input wire logic BUSY,
  input wire logic PERIPH_VALID_N,
  input wire logic PAPER_ERROR_LINE,
  input wire logic FAULT_N,
  input wire logic SELECT,
  output logic [7:0] PD_OUT,
  output logic PD_OE,
  output logic HOST_STROBE_N,
  output logic AUTO_FEED_N,
  output logic INIT_LINE_N,
  output logic SELECT_IN_N,
  output logic PORT_DMA_REQUEST,
  output logic IRQ,
  output logic SERVICE_IRQ_FLAG,
  output logic [2:0] MODE,
  output logic DIR,
  output logic FIFO_FULL,
  output logic FIFO_EMPTY,
  output logic [7:0] RDATA,
  output logic RVALID,
  output logic MOTOR_B_OUT,
  output logic DRIVE_SELECT_B_OUT,
  output logic [4:0] FDD_STATUS_OUT,
  output logic ONLINE
);
  // Link handshake phases
  typedef enum logic [2:0] {
    LK_IDLE, LK_FWD_SETUP, LK_FWD_STROBE, LK_FWD_RELEASE, LK_REV_TURN, LK_REV_WAIT, LK_REV_ACK, LK_FWD_TURN
  } link_t;

  // Whole block state
  typedef struct packed {
    link_t lk;
    logic [2:0] mode;
    logic dir;
    logic service;
    logic irq;
    logic fault_prev;
    logic [3:0] hold;
    logic [7:0] pd_out;
    logic pd_oe;
    logic strobe_n;
    logic feed_n;
    logic init_n;
    logic sel_in_n;
    logic drq;
    logic [7:0] rdata;
    logic rvalid;
    logic full;
    logic empty;
    logic motor_b_out;
    logic drive_select_b_out;
    logic [4:0] fdd;
    logic online;
  } state_t;

  state_t s_q; // Registered state
  state_t s_d; // Next state
  fifo_word_t f_out; // FIFO head
  fifo_word_t f_in; // FIFO write word
  logic [4:0] f_level; // FIFO fill
  logic f_push; // FIFO write
  logic f_pop; // FIFO read
  logic f_flush; // FIFO clear
  logic fifo_on; // FIFO usable in this mode
  logic xfer_mode; // Automatic handshake allowed
  logic host_wr_fifo; // Host write to a FIFO port
  logic host_wr_addr; // Host write to the address port
  logic host_rd_fifo; // Host read from the FIFO port
  logic dma_ok; // Mode reachable by DMA

  // Legal mode change: only via 000/001
  function automatic logic mode_ok(input logic [2:0] from, input logic [2:0] to);
    mode_ok = (from == MODE_STD) || (from == MODE_PS2) || (to == MODE_STD) || (to == MODE_PS2); // R12
  endfunction

  // Forward transfer phase in this mode and direction
  function automatic logic is_fwd(input logic [2:0] m, input logic d);
    is_fwd = (m == MODE_FIFO) || ((m == MODE_ECP) && !d);
  endfunction

  assign fifo_on = (s_q.mode == MODE_FIFO) || (s_q.mode == MODE_ECP) || (s_q.mode == MODE_TEST); // R17
  assign xfer_mode = (s_q.mode == MODE_ECP) || (s_q.mode == MODE_FIFO); // R11
  assign dma_ok = fifo_on && CTRL.dma_enable_bit && !s_q.service; // R18
  assign host_wr_fifo = HOST_REQ.wr && (HOST_REQ.addr == OFS_DATA_FIFO) && fifo_on; // R20
  assign host_wr_addr = HOST_REQ.wr && (HOST_REQ.addr == OFS_ADDR_FIFO) && (s_q.mode == MODE_ECP) && !s_q.dir; // R20
  assign host_rd_fifo = HOST_REQ.rd && (HOST_REQ.addr == OFS_DATA_FIFO) && fifo_on; // R20
  assign f_flush = !fifo_on; // R17

  // Shared FIFO behind every port
  ecp_fifo u_fifo (
    .clk(CLOCK),
    .srst(SRST),
    .flush(f_flush),
    .push(f_push),
    .push_data(f_in),
    .pop(f_pop),
    .pop_data(f_out),
    .level(f_level)
  ); // R24

  // Next state: modes, handshake, flags, pins
  always_comb
  begin
    s_d = s_q;
    f_push = 1'b0;
    f_pop = 1'b0;
    f_in = '0;
    s_d.rvalid = 1'b0;
    s_d.irq = 1'b0;
    s_d.fault_prev = FAULT_N;
    if (s_q.hold != 4'h0)
    begin
      s_d.hold = s_q.hold - 4'h1;
    end
    // Mode and direction from software
    if (CTRL.mode_wr && mode_ok(s_q.mode, CTRL.mode)) // R12
    begin
      s_d.mode = CTRL.mode; // R23
    end
    if (CTRL.mode_wr && (s_q.mode == MODE_PS2)) // R13
    begin
      s_d.dir = CTRL.dir;
    end
    // Host and DMA writes into FIFO
    if (host_wr_addr)
    begin
      f_push = 1'b1;
      f_in = '{cmd: 1'b1, data: HOST_REQ.wdata}; // R10 R16
    end
    else if (host_wr_fifo || (DMA_ACK && s_q.drq && !s_q.dir))
    begin
      f_push = 1'b1;
      f_in = '{cmd: 1'b0, data: HOST_REQ.wdata}; // R10
    end
    // Host and DMA reads out of FIFO
    if ((host_rd_fifo || (DMA_ACK && s_q.drq && s_q.dir)) && (f_level != 5'h00) && s_q.lk != LK_REV_ACK)
    begin
      f_pop = 1'b1;
      s_d.rdata = f_out.data;
      s_d.rvalid = 1'b1;
    end
    // Link handshake
    unique case (s_q.lk)
      LK_IDLE:
      begin
        if (xfer_mode && is_fwd(s_q.mode, s_q.dir) && (f_level != 5'h00) && !BUSY && !f_push) // R11 R1
        begin
          s_d.pd_out = f_out.data;
          s_d.feed_n = (s_q.mode == MODE_ECP) ? !f_out.cmd : 1'b1; // R3 R15
          s_d.hold = HOLD_CYC;
          s_d.lk = LK_FWD_SETUP;
        end
        else if (xfer_mode && (s_q.mode == MODE_ECP) && s_q.dir) // R5
        begin
          s_d.init_n = 1'b0;
          s_d.pd_oe = 1'b0;
          s_d.lk = LK_REV_TURN;
        end
      end
      LK_FWD_SETUP:
      begin
        if (s_q.hold == 4'h0)
        begin
          s_d.strobe_n = 1'b0; // R1
          s_d.hold = HOLD_CYC;
          s_d.lk = LK_FWD_STROBE;
        end
      end
      LK_FWD_STROBE:
      begin
        if ((s_q.hold == 4'h0) && BUSY) // R1
        begin
          s_d.strobe_n = 1'b1;
          f_pop = 1'b1; // Byte leaves the FIFO once the peripheral took it
          s_d.lk = LK_FWD_RELEASE;
        end
      end
      LK_FWD_RELEASE:
      begin
        if (!BUSY) // R1
        begin
          s_d.feed_n = 1'b1;
          s_d.lk = LK_IDLE;
        end
      end
      LK_REV_TURN:
      begin
        if (!PAPER_ERROR_LINE) // R6
        begin
          s_d.lk = LK_REV_WAIT;
        end
      end
      LK_REV_WAIT:
      begin
        if (!(xfer_mode && s_q.dir))
        begin
          s_d.init_n = 1'b1; // R5
          s_d.lk = LK_FWD_TURN;
        end
        else if (!PERIPH_VALID_N && (f_level != FIFO_FULL_LEVEL)) // R2
        begin
          f_push = 1'b1;
          f_in = '{cmd: !BUSY, data: PD_IN}; // R4
          s_d.feed_n = 1'b0; // R2
          s_d.lk = LK_REV_ACK;
        end
      end
      LK_REV_ACK:
      begin
        if (PERIPH_VALID_N) // R2
        begin
          s_d.feed_n = 1'b1;
          s_d.lk = LK_REV_WAIT;
        end
      end
      LK_FWD_TURN:
      begin
        if (PAPER_ERROR_LINE) // R6
        begin
          s_d.pd_oe = 1'b1;
          s_d.lk = LK_IDLE;
        end
      end
      default:
      begin
        s_d.lk = LK_IDLE;
      end
    endcase
    // Forward-only fault interrupt on falling edge
    if (s_q.fault_prev && !FAULT_N && CTRL.err_irq_en && !s_q.dir) // R7
    begin
      s_d.irq = 1'b1;
    end
    // Service flag: clear, then sets win
    if (CTRL.service_clr)
    begin
      s_d.service = 1'b0; // R21
    end
    if (CTRL.dma_enable_bit && s_q.drq && DMA_TC) // R19
    begin
      s_d.service = 1'b1;
      s_d.irq = 1'b1;
    end
    else if (!CTRL.dma_enable_bit && fifo_on && !s_q.service) // R25
    begin
      if ((!s_q.dir && (FIFO_FULL_LEVEL - f_level >= CTRL.wr_thresh)) ||
          (s_q.dir && (f_level >= CTRL.rd_thresh)))
      begin
        s_d.service = 1'b1;
        s_d.irq = 1'b1; // R21
      end
    end
    // DMA request by direction and fill
    s_d.drq = dma_ok && !(DMA_TC && s_q.drq) &&
              (s_q.dir ? (f_level > 5'h01) : (f_level < 5'h0f)); // R18 R19
    // Select-in held high in every mode; FIFO flags and online mirrored each cycle
    s_d.sel_in_n = 1'b1; // R8
    s_d.full = (f_level == FIFO_FULL_LEVEL);
    s_d.empty = (f_level == 5'h00);
    s_d.online = SELECT;
    // External floppy reuse of port pins
    s_d.motor_b_out = EXTERNAL_FLOPPY_MODE ? 1'b1 : MOTOR_B_IN; // R22
    s_d.drive_select_b_out = EXTERNAL_FLOPPY_MODE ? 1'b1 : DRIVE_SELECT_B_IN; // R22
    s_d.fdd = EXTERNAL_FLOPPY_MODE ? (FDD_STATUS_IN | PD_IN[4:0]) : FDD_STATUS_IN; // R22
  end

  // State register
  always_ff @(posedge CLOCK)
  begin
    if (SRST)
    begin
      s_q <= '{lk: LK_IDLE, mode: MODE_RESET, dir: 1'b0, service: 1'b0, irq: 1'b0, fault_prev: 1'b1,
               hold: 4'h0, pd_out: 8'h00, pd_oe: 1'b1, strobe_n: 1'b1, feed_n: 1'b1, init_n: 1'b1,
               sel_in_n: 1'b1, drq: 1'b0, rdata: 8'h00, rvalid: 1'b0, full: 1'b0, empty: 1'b1,
               motor_b_out: 1'b1, drive_select_b_out: 1'b1, fdd: 5'h00, online: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state
  assign PD_OUT = s_q.pd_out;
  assign PD_OE = s_q.pd_oe;
  assign HOST_STROBE_N = s_q.strobe_n;
  assign AUTO_FEED_N = s_q.feed_n;
  assign INIT_LINE_N = s_q.init_n;
  assign SELECT_IN_N = s_q.sel_in_n;
  assign PORT_DMA_REQUEST = s_q.drq;
  assign IRQ = s_q.irq;
  assign SERVICE_IRQ_FLAG = s_q.service;
  assign MODE = s_q.mode;
  assign DIR = s_q.dir;
  assign FIFO_FULL = s_q.full;
  assign FIFO_EMPTY = s_q.empty;
  assign RDATA = s_q.rdata;
  assign RVALID = s_q.rvalid;
  assign MOTOR_B_OUT = s_q.motor_b_out;
  assign DRIVE_SELECT_B_OUT = s_q.drive_select_b_out;
  assign FDD_STATUS_OUT = s_q.fdd;
  assign ONLINE = s_q.online;
endmodule

// >>> rtl/ecp_pkg.sv
// Shared constants and types for the extended-capabilities parallel port engine
// Function
// R1 - Forward strobe latches byte, paced by busy
// R2 - Reverse peripheral clock handshaked with host acknowledge
// R3 - Host acknowledge high data, low command forward
// R4 - Peripheral acknowledge high data, low command
// R5 - Reverse request low means reverse direction
// R6 - Drive bus only after reverse acknowledge permits
// R7 - Fault assertion raises error interrupt, forward only
// R8 - Select-in stays deasserted in ECP mode
// R9 - Software initialises direction, strobe, feed, mode
// R10 - Address port sends command, data port data
// R11 - Automatic handshake only in modes 011, 010
// R12 - Mode changes only through modes 000/001
// R13 - Direction changes only in mode 001
// R14 - Software drains FIFO before leaving transfer mode
// R15 - Command top bit marks run-length or address
// R16 - Count then byte sent, no hardware compression
// R17 - FIFO disabled after reset, FIFO/ECP modes
// R18 - DMA only to data, test, compat FIFOs
// R19 - Terminal count sets service flag, stops DMA
// R20 - Data/test FIFO at 400H, address at 000H
// R21 - Programmed I/O requests service by interrupt
// R22 - Floppy mode forces drive B off, ORs status
// R23 - Three-bit mode field selects port mode
// R24 - All ports share one 16-byte FIFO
// R25 - Threshold crossing sets service flag without DMA
package ecp_pkg;
  // Port modes
  localparam logic [2:0] MODE_STD = 3'h0;
  localparam logic [2:0] MODE_PS2 = 3'h1;
  localparam logic [2:0] MODE_FIFO = 3'h2;
  localparam logic [2:0] MODE_ECP = 3'h3;
  localparam logic [2:0] MODE_EPP = 3'h4;
  localparam logic [2:0] MODE_TEST = 3'h6;
  localparam logic [2:0] MODE_CFG = 3'h7;
  localparam logic [2:0] MODE_RESET = 3'h0;
  // Host access offsets
  localparam logic [10:0] OFS_ADDR_FIFO = 11'h000;
  localparam logic [10:0] OFS_DATA_FIFO = 11'h400;
  // FIFO shape
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_AW = 4;
  localparam logic [4:0] FIFO_FULL_LEVEL = 5'h10;
  // Command byte run-length marker
  localparam int CMD_RLE_BIT = 7;
  // Minimum data setup and strobe hold, in ns and cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOLD_NS = 40;
  localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // FIFO entry: byte plus command tag
  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } fifo_word_t;

  // Host bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [10:0] addr;
    logic [7:0] wdata;
  } host_req_t;

  // Control settings from software
  typedef struct packed {
    logic mode_wr;
    logic [2:0] mode;
    logic dir;
    logic dma_enable_bit;
    logic err_irq_en;
    logic service_clr;
    logic [4:0] wr_thresh;
    logic [4:0] rd_thresh;
  } ctrl_t;
endpackage

// >>> tb/ecp_parallel_port_engine_props.sv
// Port assertions for the parallel port engine
`timescale 1ns/1ns
module ecp_parallel_port_engine_props
  import ecp_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SRST,
  input wire ctrl_t CTRL,
  input wire logic DMA_ACK,
  input wire logic DMA_TC,
  input wire logic EXTERNAL_FLOPPY_MODE,
  input wire logic [4:0] FDD_STATUS_IN,
  input wire logic [7:0] PD_IN,
  input wire logic BUSY,
  input wire logic PAPER_ERROR_LINE,
  input wire logic FAULT_N,
  input wire logic [7:0] PD_OUT,
  input wire logic PD_OE,
  input wire logic HOST_STROBE_N,
  input wire logic INIT_LINE_N,
  input wire logic SELECT_IN_N,
  input wire logic PORT_DMA_REQUEST,
  input wire logic IRQ,
  input wire logic SERVICE_IRQ_FLAG,
  input wire logic [2:0] MODE,
  input wire logic DIR,
  input wire logic FIFO_FULL,
  input wire logic FIFO_EMPTY,
  input wire logic MOTOR_B_OUT,
  input wire logic DRIVE_SELECT_B_OUT,
  input wire logic [4:0] FDD_STATUS_OUT
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // Strobe low phase with data held
  sequence s_held;
    (!HOST_STROBE_N && $stable(PD_OUT)) [*5];
  endsequence
  property p_strobe_hold; $fell(HOST_STROBE_N) |-> s_held; endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe hold");
  property p_strobe_rel; $rose(HOST_STROBE_N) |-> $past(BUSY); endproperty
  a_strobe_rel: assert property (p_strobe_rel) else $error("strobe release");
  property p_auto; $fell(HOST_STROBE_N) |-> (MODE == MODE_ECP || MODE == MODE_FIFO); endproperty
  a_auto: assert property (p_auto) else $error("strobe outside transfer mode");
  property p_rev; !INIT_LINE_N |-> DIR; endproperty
  a_rev: assert property (p_rev) else $error("reverse request in forward");
  property p_bus; $rose(PD_OE) |-> $past(PAPER_ERROR_LINE) && INIT_LINE_N; endproperty
  a_bus: assert property (p_bus) else $error("bus driven early");
  property p_selin; SELECT_IN_N; endproperty
  a_selin: assert property (p_selin) else $error("select-in asserted");
  property p_mode; MODE != $past(MODE) |-> ($past(MODE) <= MODE_PS2 || MODE <= MODE_PS2); endproperty
  a_mode: assert property (p_mode) else $error("illegal mode change");
  property p_dir; DIR != $past(DIR) |-> $past(MODE) == MODE_PS2; endproperty
  a_dir: assert property (p_dir) else $error("direction change outside 001");
  property p_flush; (MODE == MODE_STD) [*3] |-> FIFO_EMPTY && !FIFO_FULL; endproperty
  a_flush: assert property (p_flush) else $error("fifo not off");
  property p_tc; DMA_ACK && DMA_TC && PORT_DMA_REQUEST |-> ##[1:2] (SERVICE_IRQ_FLAG && !PORT_DMA_REQUEST); endproperty
  a_tc: assert property (p_tc) else $error("terminal count");
  property p_fault; $fell(FAULT_N) && CTRL.err_irq_en && !DIR |-> ##[1:3] IRQ; endproperty
  a_fault: assert property (p_fault) else $error("fault irq");
  property p_fdd;
    EXTERNAL_FLOPPY_MODE |=> MOTOR_B_OUT && DRIVE_SELECT_B_OUT &&
      FDD_STATUS_OUT == ($past(FDD_STATUS_IN) | $past(PD_IN[4:0]));
  endproperty
  a_fdd: assert property (p_fdd) else $error("floppy outputs");
endmodule

bind ecp_parallel_port_engine ecp_parallel_port_engine_props u_props (.CLOCK, .SRST, .CTRL, .DMA_ACK, .DMA_TC,
  .EXTERNAL_FLOPPY_MODE, .FDD_STATUS_IN, .PD_IN, .BUSY, .PAPER_ERROR_LINE, .FAULT_N, .PD_OUT, .PD_OE,
  .HOST_STROBE_N, .INIT_LINE_N, .SELECT_IN_N, .PORT_DMA_REQUEST, .IRQ, .SERVICE_IRQ_FLAG, .MODE, .DIR,
  .FIFO_FULL, .FIFO_EMPTY, .MOTOR_B_OUT, .DRIVE_SELECT_B_OUT, .FDD_STATUS_OUT);

// >>> tb/ecp_parallel_port_engine_tb.sv
// Self-checking bench for the parallel port engine
`timescale 1ns/1ns
module ecp_parallel_port_engine_tb
  import ecp_pkg::*;
;
  logic CLOCK = 1'b0;
  logic SRST = 1'b1;
  host_req_t HOST_REQ = '0;
  ctrl_t CTRL = '0;
  logic DMA_ACK = 1'b0, DMA_TC = 1'b0, EXTERNAL_FLOPPY_MODE = 1'b0, FAULT_N = 1'b1;
  logic MOTOR_B_IN = 1'b0, DRIVE_SELECT_B_IN = 1'b0;
  logic [4:0] FDD_STATUS_IN = 5'h0a;
  logic [7:0] PD_IN, PD_OUT, RDATA, cap_n, n0;
  logic [2:0] MODE;
  logic [4:0] FDD_STATUS_OUT;
  logic [17:0] cap;
  logic BUSY, PERIPH_VALID_N, PAPER_ERROR_LINE, PD_OE, HOST_STROBE_N, AUTO_FEED_N, INIT_LINE_N, SELECT_IN_N;
  logic PORT_DMA_REQUEST, IRQ, SERVICE_IRQ_FLAG, DIR, FIFO_FULL, FIFO_EMPTY, RVALID, MOTOR_B_OUT;
  logic DRIVE_SELECT_B_OUT, ONLINE;
  int bad_count = 0, check_count = 0, i;
  // Rows: requested mode, dir, then expected mode, dir
  logic [7:0] rows [18] = '{8'h10, 8'h32, 8'h33, 8'h22, 8'h66, 8'hc6, 8'h46, 8'h00, 8'hcc,
    8'hec, 8'h22, 8'h44, 8'h84, 8'h00, 8'h88, 8'h22, 8'hee, 8'h00};

  // Free-running clock
  always #4 CLOCK = ~CLOCK;

  ecp_parallel_port_engine dut (.CLOCK, .SRST, .HOST_REQ, .CTRL, .DMA_ACK, .DMA_TC,
    .EXTERNAL_FLOOPY_UNUSED_N(1'b1), .EXTERNAL_FLOPPY_MODE, .MOTOR_B_IN, .DRIVE_SELECT_B_IN, .FDD_STATUS_IN,
    .PD_IN, .BUSY, .PERIPH_VALID_N, .PAPER_ERROR_LINE, .FAULT_N, .SELECT(1'b1), .PD_OUT, .PD_OE,
    .HOST_STROBE_N, .AUTO_FEED_N, .INIT_LINE_N, .SELECT_IN_N, .PORT_DMA_REQUEST, .IRQ, .SERVICE_IRQ_FLAG,
    .MODE, .DIR, .FIFO_FULL, .FIFO_EMPTY, .RDATA, .RVALID, .MOTOR_B_OUT, .DRIVE_SELECT_B_OUT,
    .FDD_STATUS_OUT, .ONLINE);

  ecp_periph_model u_per (.clk(CLOCK), .host_strobe_n(HOST_STROBE_N), .auto_feed_n(AUTO_FEED_N),
    .init_line_n(INIT_LINE_N), .pd_out(PD_OUT), .busy(BUSY), .periph_valid_n(PERIPH_VALID_N),
    .paper_error_line(PAPER_ERROR_LINE), .pd_in(PD_IN), .cap(cap), .cap_n(cap_n));

  // Compare and count
  task automatic chk(input string nm, input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Mode write pulse
  task automatic md(input logic [2:0] m, input logic d);
    @(negedge CLOCK);
    CTRL.mode <= m;
    CTRL.dir <= d;
    CTRL.mode_wr <= 1'b1;
    @(negedge CLOCK);
    CTRL.mode_wr <= 1'b0;
  endtask

  // Host FIFO write pulse
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(negedge CLOCK);
    HOST_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge CLOCK);
    HOST_REQ.wr <= 1'b0;
  endtask

  // Host FIFO read, answer one cycle later
  task automatic rd(input logic [7:0] e);
    @(negedge CLOCK);
    HOST_REQ <= '{wr: 1'b0, rd: 1'b1, addr: OFS_DATA_FIFO, wdata: 8'h00};
    @(negedge CLOCK);
    HOST_REQ.rd <= 1'b0;
    chk("rdata", {RVALID, RDATA}, {1'b1, e});
  endtask

  // DMA cycle, optional terminal count
  task automatic dack(input logic tc, input logic [7:0] d);
    @(negedge CLOCK);
    DMA_ACK <= 1'b1;
    DMA_TC <= tc;
    HOST_REQ.wdata <= d;
    @(negedge CLOCK);
    DMA_ACK <= 1'b0;
    DMA_TC <= 1'b0;
  endtask

  // Service flag clear pulse, with DMA setting
  task automatic sclr(input logic dma);
    @(negedge CLOCK);
    CTRL.dma_enable_bit <= dma;
    CTRL.service_clr <= 1'b1;
    @(negedge CLOCK);
    CTRL.service_clr <= 1'b0;
  endtask

  // Wait until the forward link is idle and empty
  task automatic drain;
    for (i = 0; i < 400 && !(FIFO_EMPTY && AUTO_FEED_N && !BUSY); i++) @(negedge CLOCK);
    repeat (2) @(negedge CLOCK);
  endtask

  // Main sequence
  initial
  begin
    CTRL.err_irq_en = 1'b1;
    CTRL.rd_thresh = 5'h02;
    CTRL.wr_thresh = 5'h10;
    repeat (3) @(negedge CLOCK);
    chk("reset", {MODE, DIR, INIT_LINE_N, SELECT_IN_N, HOST_STROBE_N, AUTO_FEED_N, PD_OE, PORT_DMA_REQUEST,
      SERVICE_IRQ_FLAG, FIFO_EMPTY, FIFO_FULL}, {MODE_RESET, 10'h1f2});
    SRST <= 1'b0;
    for (i = 0; i < 18; i++)
    begin
      md(rows[i][7:5], rows[i][4]);
      chk("mode", {MODE, DIR}, rows[i][3:0]);
    end
    // Forward command then data
    md(MODE_ECP, 1'b0);
    n0 = cap_n;
    wr(OFS_ADDR_FIFO, 8'h85);
    wr(OFS_DATA_FIFO, 8'h41);
    @(negedge CLOCK);
    FAULT_N <= 1'b0;
    @(negedge CLOCK);
    chk("fault_irq", IRQ, 1'b1);
    repeat (3) @(negedge CLOCK);
    FAULT_N <= 1'b1;
    drain();
    chk("fwd", cap, {1'b1, 8'h85, 1'b0, 8'h41});
    chk("fwd_n", cap_n, n0 + 8'h02);
    md(MODE_STD, 1'b0);
    // Test FIFO fill past full, no transmit, drain
    md(MODE_TEST, 1'b0);
    n0 = cap_n;
    for (i = 0; i < 17; i++) wr(OFS_DATA_FIFO, 8'(8'h20 + i));
    chk("full", FIFO_FULL, 1'b1);
    chk("tx", cap_n, n0);
    for (i = 0; i < 16; i++) rd(8'(8'h20 + i));
    @(negedge CLOCK);
    chk("empty", FIFO_EMPTY, 1'b1);
    // Leftover bytes are thrown away on the way back to mode 000
    wr(OFS_DATA_FIFO, 8'h55);
    wr(OFS_DATA_FIFO, 8'h56);
    chk("refill", FIFO_EMPTY, 1'b0);
    md(MODE_STD, 1'b0);
    repeat (2) @(negedge CLOCK);
    chk("flush", {FIFO_EMPTY, FIFO_FULL}, 2'b10);
    // DMA in FIFO mode up to terminal count
    sclr(1'b1);
    md(MODE_FIFO, 1'b0);
    n0 = cap_n;
    for (i = 0; i < 50 && PORT_DMA_REQUEST !== 1'b1; i++) @(negedge CLOCK);
    chk("drq", {PORT_DMA_REQUEST, SERVICE_IRQ_FLAG}, 2'b10);
    dack(1'b0, 8'h66);
    dack(1'b1, 8'h67);
    chk("tc", {PORT_DMA_REQUEST, SERVICE_IRQ_FLAG}, 2'b01);
    drain();
    chk("dma_tx", {cap_n, cap[8:0]}, {n0 + 8'h02, 1'b0, 8'h67});
    md(MODE_STD, 1'b0);
    sclr(1'b0);
    chk("clr", SERVICE_IRQ_FLAG, 1'b0);
    // Reverse transfer of data then command
    md(MODE_PS2, 1'b1);
    md(MODE_PS2, 1'b1);
    md(MODE_ECP, 1'b1);
    repeat (2) @(negedge CLOCK);
    chk("rev", {INIT_LINE_N, PD_OE, SERVICE_IRQ_FLAG}, 3'b000);
    for (i = 0; i < 300 && SERVICE_IRQ_FLAG !== 1'b1; i++) @(negedge CLOCK);
    chk("rthr", SERVICE_IRQ_FLAG, 1'b1);
    rd(8'h5a);
    rd(8'h12);
    md(MODE_PS2, 1'b1);
    md(MODE_PS2, 1'b0);
    for (i = 0; i < 50 && PD_OE !== 1'b1; i++) @(negedge CLOCK);
    chk("fwd_back", {INIT_LINE_N, PD_OE, DIR}, 3'b110);
    // Floppy pins pass through, then forced off
    chk("fdd_off", {MOTOR_B_OUT, DRIVE_SELECT_B_OUT, FDD_STATUS_OUT, ONLINE}, {2'b00, FDD_STATUS_IN, 1'b1});
    EXTERNAL_FLOPPY_MODE <= 1'b1;
    repeat (2) @(negedge CLOCK);
    chk("fdd_on", {MOTOR_B_OUT, DRIVE_SELECT_B_OUT}, 2'b11);
    wrap_up();
  end

  // Watchdog
  initial
  begin
    #100000;
    bad_count++;
    wrap_up();
  end
endmodule

// >>> tb/ecp_periph_model.sv
// Behavioural peripheral: forward byte sink and reverse byte source
`timescale 1ns/1ns
module ecp_periph_model
(
  input wire logic clk,
  input wire logic host_strobe_n,
  input wire logic auto_feed_n,
  input wire logic init_line_n,
  input wire logic [7:0] pd_out,
  output logic busy,
  output logic periph_valid_n,
  output logic paper_error_line,
  output logic [7:0] pd_in,
  output logic [17:0] cap,
  output logic [7:0] cap_n
);
  // One reverse byte, tagged on busy, paced by host acknowledge
  task automatic send(input logic [7:0] b, input logic cmd);
    int i;
    @(posedge clk);
    pd_in <= b;
    busy <= !cmd;
    @(posedge clk);
    periph_valid_n <= 1'b0;
    for (i = 0; i < 64 && auto_feed_n; i++) @(posedge clk);
    periph_valid_n <= 1'b1;
    for (i = 0; i < 64 && !auto_feed_n; i++) @(posedge clk);
  endtask

  // Peripheral sequencing
  initial
  begin
    busy = 1'b0;
    periph_valid_n = 1'b1;
    paper_error_line = 1'b1;
    pd_in = 8'h00;
    cap = '0;
    cap_n = '0;
    forever
    begin
      @(posedge clk);
      pd_in <= ~pd_in; // Undriven bus keeps moving
      if (!init_line_n)
      begin
        repeat (4) @(posedge clk);
        paper_error_line <= 1'b0;
        send(8'h5a, 1'b0);
        send(8'h12, 1'b1);
        while (!init_line_n) @(posedge clk);
        paper_error_line <= 1'b1;
        busy <= 1'b0;
      end
      else if (!host_strobe_n && !busy)
      begin
        busy <= 1'b1;
        cap <= {cap[8:0], !auto_feed_n, pd_out};
        cap_n <= cap_n + 8'h01;
      end
      else if (host_strobe_n && busy)
        busy <= 1'b0;
    end
  end
endmodule
